// [common/spm_pkg.sv]
// Package for the shared-function pin multiplexer: map, layouts, carriers.
// Function
// RULE_01 - Every reset leaves all pins as digital inputs, drivers and functions off.
// RULE_02 - Timer compare pins float while protect input is low and unmasked.
// RULE_03 - Simple compare pins float while protect input is low and unmasked.
// RULE_04 - Simple compare pin level follows compare output shaped by action control.
// RULE_05 - Port B bits 0 to 2 carry simple compare outputs 1 to 3.
// RULE_06 - Port B bits 3 to 5 carry timer 1 to 3 compare outputs.
// RULE_07 - Direction pin low counts timers up, high counts them down.
// RULE_08 - Port B bit 7 feeds an external clock to the timers.
// RULE_09 - Port C bit 0 feeds an external start trigger to the converter.
// RULE_10 - Port A bits 0 and 1 serve as first converter analog inputs.
// RULE_11 - Port A bits 2 and 3 serve as second converter analog inputs.
// RULE_12 - Per-pin function select, direction, stored output and readable input level.
package spm_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Pin order on the pad bus.
  localparam int SPM_NPINS = 13;
  localparam int SPM_A0    = 0;
  localparam int SPM_A1    = 1;
  localparam int SPM_A2    = 2;
  localparam int SPM_A3    = 3;
  localparam int SPM_B0    = 4;
  localparam int SPM_B3    = 7;
  localparam int SPM_B6    = 10;
  localparam int SPM_B7    = 11;
  localparam int SPM_C0    = 12;
  localparam int SPM_NCMP  = 3;

  ////////////////////////////////////////////////////////////////////////////
  // Register map, byte addresses.
  localparam int         SPM_AW        = 5;
  localparam logic [4:0] SPM_OFF_FUNC  = 5'h00;
  localparam logic [4:0] SPM_OFF_DIR   = 5'h04;
  localparam logic [4:0] SPM_OFF_DOUT  = 5'h08;
  localparam logic [4:0] SPM_OFF_DIN   = 5'h0c;
  localparam logic [4:0] SPM_OFF_SACT  = 5'h10;
  localparam logic [4:0] SPM_OFF_CTRL  = 5'h14;
  localparam logic [4:0] SPM_OFF_STAT  = 5'h18;

  // Control and status bit positions.
  localparam int SPM_CTRL_UNMASK = 0;
  localparam int SPM_STAT_FLOAT  = 0;
  localparam int SPM_STAT_PDP    = 1;

  // Reset values.
  localparam logic [12:0] SPM_FUNC_RST  = 13'h0000;
  localparam logic [12:0] SPM_DIR_RST   = 13'h0000;
  localparam logic [12:0] SPM_DOUT_RST  = 13'h0000;
  localparam logic [12:0] SPM_OE_N_RST  = 13'h1fff;
  localparam logic [5:0]  SPM_SACT_RST  = 6'h00;

  // Action control codes, two bits per simple compare output.
  localparam int         SPM_SACT_W   = 2;
  localparam logic [1:0] SPM_ACT_LO   = 2'h0;
  localparam logic [1:0] SPM_ACT_ALO  = 2'h1;
  localparam logic [1:0] SPM_ACT_AHI  = 2'h2;
  localparam logic [1:0] SPM_ACT_HI   = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Carriers.
  typedef struct packed {
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hready;
  } spm_ahb_req_t;

  typedef struct packed {
    logic [31:0] hrdata;
    logic        hreadyout;
    logic        hresp;
  } spm_ahb_rsp_t;

  typedef struct packed {
    logic [12:0] out;
    logic [12:0] oe_n;
  } spm_pad_t;

  typedef struct packed {
    logic [2:0] simple_cmp;
    logic [2:0] timer_cmp;
  } spm_per_in_t;

  typedef struct packed {
    logic       timer_count_down;
    logic       timer_ext_clk;
    logic       converter_start_trigger;
    logic [1:0] first_conv_en;
    logic [1:0] second_conv_en;
  } spm_per_out_t;

  // Shapes one simple compare output by its action control code.
  function automatic logic spm_shape(input logic [1:0] act,
                                     input logic       raw);
    logic r;
    r = 1'b0;
    case (act)
      SPM_ACT_LO:  r = 1'b0;
      SPM_ACT_ALO: r = ~raw;
      SPM_ACT_AHI: r = raw;
      SPM_ACT_HI:  r = 1'b1;
      default:     r = 1'b0;
    endcase
    return r;
  endfunction

endpackage

// [hdl/spm_sync.sv]
// Three-stage pin synchroniser with an agreement filter.
`timescale 1ns/1ps
`default_nettype none
module spm_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] din,
  output var  logic [W-1:0] dout
);
  import spm_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] stable;
  } spm_sync_st_t;

  spm_sync_st_t s_q;
  spm_sync_st_t s_d;

  // The first stage feeds only the second; a level is taken once the
  // second and third stages agree, which drops single-cycle glitches.
  always_comb begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    for (int i = 0; i < W; i++) begin
      if (s_q.s2[i] == s_q.s3[i]) begin
        s_d.stable[i] = s_q.s3[i];
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign dout = s_q.stable;

endmodule
`default_nettype wire

// [hdl/spm_pin_mux.sv]
// Shared-function pin multiplexer with AHB-Lite register slave.
`timescale 1ns/1ps
`default_nettype none
module spm_pin_mux (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire spm_pkg::spm_ahb_req_t ahb_i,
  output var  spm_pkg::spm_ahb_rsp_t ahb_o,
  input  wire logic [12:0]           pad_in,
  input  wire logic                  power_drive_protect_irq_n,
  output var  spm_pkg::spm_pad_t     pad_o,
  input  wire spm_pkg::spm_per_in_t  per_i,
  output var  spm_pkg::spm_per_out_t per_o
);
  import spm_pkg::*;

  typedef struct packed {
    logic [12:0]  func;
    logic [12:0]  dir;
    logic [12:0]  dout;
    logic [5:0]   sact;
    logic         unmask;
    logic         ph_valid;
    logic         ph_write;
    logic [4:0]   ph_addr;
    logic [31:0]  rdata;
    logic         hready;
    logic [12:0]  pad_out;
    logic [12:0]  pad_oe_n;
    spm_per_out_t per;
  } spm_st_t;

  spm_st_t     s_q;
  spm_st_t     s_d;
  logic [13:0] sync_w;
  logic [12:0] pin_s;
  logic        pdp_n_s;
  logic        float_w;

  ////////////////////////////////////////////////////////////////////////////
  // Pins and the protect input come from the board, so they are synchronised.
  // The protect level travels inverted, so a cleared synchroniser reads as
  // idle and no false protect event follows reset.
  spm_sync #(
    .W (14)
  ) i_spm_sync (
    .clk  (clk),
    .rst  (rst),
    .din  ({~power_drive_protect_irq_n, pad_in}),
    .dout (sync_w)
  );

  assign pin_s   = sync_w[12:0];
  assign pdp_n_s = ~sync_w[13];

  // Unmasked protect input held low floats every compare-type output.
  assign float_w = s_q.unmask && !pdp_n_s; // [RULE_02] [RULE_03]

  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rd_mux(input spm_st_t    st,
                                         input logic [4:0]  a,
                                         input logic [12:0] pins,
                                         input logic        flt,
                                         input logic        pdp);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      SPM_OFF_FUNC: r[12:0] = st.func;
      SPM_OFF_DIR:  r[12:0] = st.dir;
      SPM_OFF_DOUT: r[12:0] = st.dout;
      SPM_OFF_DIN:  r[12:0] = pins; // [RULE_12]
      SPM_OFF_SACT: r[5:0]  = st.sact;
      SPM_OFF_CTRL: r[SPM_CTRL_UNMASK] = st.unmask;
      SPM_OFF_STAT: begin
        r[SPM_STAT_FLOAT] = flt;
        r[SPM_STAT_PDP]   = pdp;
      end
      default:      r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    s_d = s_q;
    s_d.hready = 1'b1;

    // Data phase of a write: the address was caught in the previous cycle.
    if (s_q.ph_valid && s_q.ph_write) begin
      case (s_q.ph_addr)
        SPM_OFF_FUNC: s_d.func   = ahb_i.hwdata[12:0]; // [RULE_12]
        SPM_OFF_DIR:  s_d.dir    = ahb_i.hwdata[12:0]; // [RULE_12]
        SPM_OFF_DOUT: s_d.dout   = ahb_i.hwdata[12:0]; // [RULE_12]
        SPM_OFF_SACT: s_d.sact   = ahb_i.hwdata[5:0];  // [RULE_04]
        SPM_OFF_CTRL: s_d.unmask = ahb_i.hwdata[SPM_CTRL_UNMASK];
        default:      s_d.unmask = s_q.unmask;
      endcase
    end

    s_d.ph_valid = ahb_i.hsel && ahb_i.htrans[1] && ahb_i.hready;
    s_d.ph_write = ahb_i.hwrite;
    s_d.ph_addr  = ahb_i.haddr[SPM_AW-1:0];

    // Read data comes from the next-state copy, so a read right behind a
    // write sees the new value with no wait state.
    if (s_d.ph_valid && !ahb_i.hwrite) begin
      s_d.rdata = rd_mux(s_d, ahb_i.haddr[SPM_AW-1:0], pin_s, float_w,
                         pdp_n_s);
    end else begin
      s_d.rdata = 32'h0000_0000;
    end

    // Plain I/O by default; a selected function releases the driver, except the compare functions on port B bits 0 to 5, set below.
    for (int i = 0; i < SPM_NPINS; i++) begin
      if (!s_q.func[i]) begin
        s_d.pad_out[i]  = s_q.dout[i];  // [RULE_12]
        s_d.pad_oe_n[i] = ~s_q.dir[i];  // [RULE_12]
      end else begin
        s_d.pad_out[i]  = 1'b0;         // [RULE_10] [RULE_11]
        s_d.pad_oe_n[i] = 1'b1;
      end
    end

    for (int j = 0; j < SPM_NCMP; j++) begin
      if (s_q.func[SPM_B0+j]) begin
        s_d.pad_out[SPM_B0+j]  = // [RULE_04] [RULE_05]
          spm_shape(s_q.sact[SPM_SACT_W*j +: 2], per_i.simple_cmp[j]);
        s_d.pad_oe_n[SPM_B0+j] = float_w; // [RULE_03]
      end
      if (s_q.func[SPM_B3+j]) begin
        s_d.pad_out[SPM_B3+j]  = per_i.timer_cmp[j]; // [RULE_06]
        s_d.pad_oe_n[SPM_B3+j] = float_w;            // [RULE_02]
      end
    end

    // Inputs to peripherals rest inactive when their function is off.
    s_d.per.timer_count_down = s_q.func[SPM_B6] && pin_s[SPM_B6]; // [RULE_07]
    s_d.per.timer_ext_clk    = s_q.func[SPM_B7] && pin_s[SPM_B7]; // [RULE_08]
    s_d.per.converter_start_trigger =
      s_q.func[SPM_C0] && pin_s[SPM_C0];                        // [RULE_09]
    s_d.per.first_conv_en  = {s_q.func[SPM_A1], s_q.func[SPM_A0]}; // [RULE_10]
    // Bit 0 is analog input 8 on port A bit 3, bit 1 is input 9 on bit 2.
    s_d.per.second_conv_en = {s_q.func[SPM_A2], s_q.func[SPM_A3]}; // [RULE_11]
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      s_q          <= '0;                   // [RULE_01]
      s_q.func     <= SPM_FUNC_RST;         // [RULE_01]
      s_q.dir      <= SPM_DIR_RST;          // [RULE_01]
      s_q.dout     <= SPM_DOUT_RST;
      s_q.sact     <= SPM_SACT_RST;
      s_q.pad_oe_n <= SPM_OE_N_RST;         // [RULE_01]
      s_q.hready   <= 1'b1;
    end else begin
      s_q <= s_d;
    end
  end

  assign ahb_o.hrdata    = s_q.rdata;
  assign ahb_o.hreadyout = s_q.hready;
  assign ahb_o.hresp     = 1'b0;
  assign pad_o.out       = s_q.pad_out;
  assign pad_o.oe_n      = s_q.pad_oe_n;
  assign per_o           = s_q.per;

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  logic shp0_w;
  logic shp1_w;
  // shp0_w is written out apart from the shaping function, so a wrong code table shows; shp1_w calls it.
  assign shp0_w = s_q.sact[1] ? (s_q.sact[0] | per_i.simple_cmp[0])
                              : (s_q.sact[0] & ~per_i.simple_cmp[0]);
  assign shp1_w = spm_shape(s_q.sact[3:2], per_i.simple_cmp[1]);

  property p_reset_input;
    @(posedge clk) rst |=> (pad_o.oe_n == SPM_OE_N_RST) && (s_q.func == '0)
      && (per_o == '0);
  endproperty
  a_reset_input: assert property (p_reset_input) // [RULE_01]
    else $error("pins not released to input after reset");

  property p_timer_float;
    @(posedge clk) disable iff (rst)
      (float_w && (&s_q.func[SPM_B3 +: SPM_NCMP])) |=>
        (&pad_o.oe_n[SPM_B3 +: SPM_NCMP]);
  endproperty
  a_timer_float: assert property (p_timer_float) // [RULE_02]
    else $error("timer compare pin driven during protect");

  property p_simple_float;
    @(posedge clk) disable iff (rst)
      (float_w && (&s_q.func[SPM_B0 +: SPM_NCMP])) |=>
        (&pad_o.oe_n[SPM_B0 +: SPM_NCMP]);
  endproperty
  a_simple_float: assert property (p_simple_float) // [RULE_03]
    else $error("simple compare pin driven during protect");

  property p_simple_shape;
    @(posedge clk) disable iff (rst)
      (s_q.func[SPM_B0] && !float_w) |=>
        (pad_o.out[SPM_B0] == $past(shp0_w)) && !pad_o.oe_n[SPM_B0];
  endproperty
  a_simple_shape: assert property (p_simple_shape) // [RULE_04]
    else $error("simple compare 1 level wrong");

  property p_simple_map;
    @(posedge clk) disable iff (rst)
      (s_q.func[SPM_B0+1] && !float_w) |=>
        pad_o.out[SPM_B0+1] == $past(shp1_w);
  endproperty
  a_simple_map: assert property (p_simple_map) // [RULE_05]
    else $error("simple compare 2 not on port B bit 1");

  property p_timer_map;
    @(posedge clk) disable iff (rst)
      (s_q.func[SPM_B3+1] && !float_w) |=>
        (pad_o.out[SPM_B3+1] == $past(per_i.timer_cmp[1]))
        && !pad_o.oe_n[SPM_B3+1];
  endproperty
  a_timer_map: assert property (p_timer_map) // [RULE_06]
    else $error("timer 2 compare not on port B bit 4");

  property p_count_dir;
    @(posedge clk) disable iff (rst)
      s_q.func[SPM_B6] |=> per_o.timer_count_down == $past(pin_s[SPM_B6]);
  endproperty
  a_count_dir: assert property (p_count_dir) // [RULE_07]
    else $error("count direction does not follow pin");

  property p_ext_clk;
    @(posedge clk) disable iff (rst)
      s_q.func[SPM_B7] ##1 s_q.func[SPM_B7] |->
        per_o.timer_ext_clk == $past(pin_s[SPM_B7]);
  endproperty
  a_ext_clk: assert property (p_ext_clk) // [RULE_08]
    else $error("external timer clock not routed");

  property p_soc;
    @(posedge clk) disable iff (rst)
      !s_q.func[SPM_C0] |=> !per_o.converter_start_trigger;
  endproperty
  a_soc: assert property (p_soc) // [RULE_09]
    else $error("start trigger active with function off");

  property p_first_conv;
    @(posedge clk) disable iff (rst)
      s_q.func[SPM_A0] |=> per_o.first_conv_en[0] && pad_o.oe_n[SPM_A0];
  endproperty
  a_first_conv: assert property (p_first_conv) // [RULE_10]
    else $error("first converter input not released");

  property p_second_conv;
    @(posedge clk) disable iff (rst)
      s_q.func[SPM_A3] |=> per_o.second_conv_en[0] && pad_o.oe_n[SPM_A3];
  endproperty
  a_second_conv: assert property (p_second_conv) // [RULE_11]
    else $error("second converter input 8 not released");

  property p_gpio_drive;
    @(posedge clk) disable iff (rst)
      (!s_q.func[SPM_C0] && s_q.dir[SPM_C0]) |=>
        !pad_o.oe_n[SPM_C0] && (pad_o.out[SPM_C0] == $past(s_q.dout[SPM_C0]));
  endproperty
  a_gpio_drive: assert property (p_gpio_drive) // [RULE_12]
    else $error("port C bit 0 output not driven");

  property p_mask_drive;
    @(posedge clk) disable iff (rst)
      (s_q.func[SPM_B3] && !s_q.unmask) |=> !pad_o.oe_n[SPM_B3];
  endproperty
  a_mask_drive: assert property (p_mask_drive) // [RULE_02]
    else $error("masked protect floated timer 1 compare pin");

  property p_timer_all;
    @(posedge clk) disable iff (rst)
      (&s_q.func[SPM_B3 +: SPM_NCMP]) |=>
        pad_o.out[SPM_B3 +: SPM_NCMP] == $past(per_i.timer_cmp);
  endproperty
  a_timer_all: assert property (p_timer_all) // [RULE_06]
    else $error("timer compare outputs not on port B bits 3 to 5");

  property p_soc_route;
    @(posedge clk) disable iff (rst)
      s_q.func[SPM_C0] |=>
        per_o.converter_start_trigger == $past(pin_s[SPM_C0]);
  endproperty
  a_soc_route: assert property (p_soc_route) // [RULE_09]
    else $error("start trigger does not follow port C bit 0");

  property p_second_conv9;
    @(posedge clk) disable iff (rst)
      s_q.func[SPM_A2] |=> per_o.second_conv_en[1] && pad_o.oe_n[SPM_A2];
  endproperty
  a_second_conv9: assert property (p_second_conv9) // [RULE_11]
    else $error("second converter input 9 not released");

  property p_gpio_input;
    @(posedge clk) disable iff (rst)
      (!s_q.func[SPM_A0] && !s_q.dir[SPM_A0]) |=> pad_o.oe_n[SPM_A0];
  endproperty
  a_gpio_input: assert property (p_gpio_input) // [RULE_12]
    else $error("port A bit 0 driven while set as input");

  c_float: cover property (@(posedge clk) disable iff (rst)
    s_q.func[SPM_B3] ##1 float_w);
  c_write: cover property (@(posedge clk) disable iff (rst)
    s_q.ph_valid && s_q.ph_write && s_q.ph_addr == SPM_OFF_FUNC);
  c_gpio: cover property (@(posedge clk) disable iff (rst)
    !pad_o.oe_n[SPM_A0]);
  c_inverted: cover property (@(posedge clk) disable iff (rst)
    s_q.func[SPM_B0] && s_q.sact[1:0] == SPM_ACT_ALO);
  c_count_down: cover property (@(posedge clk) disable iff (rst)
    s_q.func[SPM_B6] && per_o.timer_count_down);

endmodule
`default_nettype wire

// [sim/spm_board.sv]
// Board-side model that resolves each shared pin from both drivers.
`timescale 1ns/1ps
`default_nettype none
module spm_board (
  input  wire spm_pkg::spm_pad_t pad_o,
  input  wire logic [12:0]       ext,
  output var  logic [12:0]       pad_in
);
  import spm_pkg::*;
  // The board always drives, so a pin the device releases shows the board
  // level rather than a stale device value.
  always_comb begin
    for (int i = 0; i < SPM_NPINS; i++) begin
      pad_in[i] = pad_o.oe_n[i] ? ext[i] : pad_o.out[i];
    end
  end
endmodule
`default_nettype wire

// [sim/shared_function_pin_mux_test.sv]
// Self-checking testbench for the shared-function pin multiplexer.
`timescale 1ns/1ps
`default_nettype none
module shared_function_pin_mux_test;
  import spm_pkg::*;
  logic         clk = 1'b0;
  logic         rst = 1'b1;
  spm_ahb_req_t req = '0;
  spm_ahb_req_t ahb_i;
  spm_ahb_rsp_t ahb_o;
  logic [12:0]  pad_in;
  logic [12:0]  ext = 13'h0000;
  logic         prot_n = 1'b1;
  spm_pad_t     pad_o;
  spm_per_in_t  per_i = '0;
  spm_per_out_t per_o;
  logic         rd_ph = 1'b0;
  logic [31:0]  exp_q[$];
  string        nm_q[$];
  int           failures = 0;
  int           n_compared = 0;
  int           cyc = 0;
  logic [31:0]  v;
  logic [5:0]   s;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    ahb_i = req;
    ahb_i.hready = ahb_o.hreadyout;
  end

  spm_pin_mux i_spm_pin_mux (.clk(clk), .rst(rst), .ahb_i(ahb_i),
    .ahb_o(ahb_o), .pad_in(pad_in), .power_drive_protect_irq_n(prot_n),
    .pad_o(pad_o), .per_i(per_i), .per_o(per_o));
  spm_board i_spm_board (.pad_o(pad_o), .ext(ext), .pad_in(pad_in));

  initial forever #12.5 clk = ~clk;

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] e,
                     input logic [31:0] sn);
    n_compared++;
    if (sn !== e) begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, sn);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // For a read, d is the expected word and goes to the watcher's queue.
  task automatic bus(input logic wr, input logic [4:0] a,
                     input logic [31:0] d, input string nm = "rd");
    req.hsel   <= 1'b1;
    req.htrans <= 2'h2;
    req.haddr  <= {27'h000_0000, a};
    req.hwrite <= wr;
    req.hsize  <= 3'h2;
    do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
    req.hsel   <= 1'b0;
    req.htrans <= 2'h0;
    req.hwdata <= wr ? d : 32'h0000_0000;
    rd_ph      <= ~wr;
    if (!wr) begin
      exp_q.push_back(d);
      nm_q.push_back(nm);
    end
    do @(posedge clk); while (ahb_o.hreadyout !== 1'b1);
    rd_ph <= 1'b0;
  endtask

  // Own encoding of the action codes: low, inverted, direct, high.
  function automatic logic shp(input logic [1:0] c, input logic r);
    return c[1] ? (c[0] | r) : (c[0] & ~r);
  endfunction

  always @(posedge clk) begin
    if (rd_ph && ahb_o.hreadyout === 1'b1 && exp_q.size() > 0) begin
      chk(nm_q.pop_front(), exp_q.pop_front(), ahb_o.hrdata);
      chk("hresp", 32'h0000_0000, 32'(ahb_o.hresp));
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 5000) begin
      failures++;
      give_verdict();
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(11639));
    wt(6);
    rst <= 1'b0;
    wt(1);
    chk("oe_n_rst", 32'h0000_1fff, 32'(pad_o.oe_n));
    chk("per_rst", 32'h0000_0000, 32'(per_o));
    // Status shows the idle-high protect level in bit 1 after reset.
    for (int a = 0; a < 32; a += 4) begin
      v = (5'(a) == SPM_OFF_STAT) ? 32'h0000_0002 : 32'h0000_0000;
      bus(1'b0, 5'(a), v, "reg_rst");
    end
    v = {19'h0_0000, 13'($urandom())};
    bus(1'b1, SPM_OFF_DIR, 32'h0000_1fff);
    bus(1'b1, SPM_OFF_DOUT, v);
    wt(3);
    chk("gpio_out", v, 32'(pad_o.out));
    chk("gpio_oe_n", 32'h0000_0000, 32'(pad_o.oe_n));
    bus(1'b0, SPM_OFF_DOUT, v, "dout");
    bus(1'b1, SPM_OFF_DIR, 32'h0000_0000);
    v = {19'h0_0000, 13'($urandom())};
    ext <= v[12:0];
    wt(6);
    bus(1'b0, SPM_OFF_DIN, v, "din");
    bus(1'b1, SPM_OFF_FUNC, 32'h0000_03f0);
    // Each channel gets a different code so a crossed mapping shows.
    for (int k = 0; k < 4; k++) begin
      for (int j = 0; j < 3; j++) s[2*j +: 2] = 2'(k + j);
      bus(1'b1, SPM_OFF_SACT, {26'h000_0000, s});
      per_i <= 6'($urandom());
      wt(3);
      for (int j = 0; j < 3; j++) begin
        chk("cmp_pin", 32'(shp(s[2*j +: 2], per_i.simple_cmp[j])),
            32'(pad_o.out[4+j]));
        chk("tmr_pin", 32'(per_i.timer_cmp[j]),
            32'(pad_o.out[7+j]));
      end
      chk("cmp_oe_n", 32'h0000_0000, 32'(pad_o.oe_n[9:4]));
    end
    bus(1'b1, SPM_OFF_CTRL, 32'h0000_0001);
    prot_n <= 1'b0;
    wt(6);
    chk("float_oe_n", 32'h0000_003f,
        32'(pad_o.oe_n[9:4]));
    bus(1'b0, SPM_OFF_STAT, 32'h0000_0001, "stat");
    bus(1'b1, SPM_OFF_CTRL, 32'h0000_0000);
    wt(4);
    chk("mask_oe_n", 32'h0000_0000,
        32'(pad_o.oe_n[9:4]));
    prot_n <= 1'b1;
    bus(1'b1, SPM_OFF_FUNC, 32'h0000_1fff);
    v = {19'h0_0000, 13'($urandom())};
    for (int k = 0; k < 2; k++) begin
      ext <= v[12:0] ^ {13{k[0]}};
      wt(6);
      chk("dir", 32'(ext[10]), 32'(per_o.timer_count_down));
      chk("tclk", 32'(ext[11]), 32'(per_o.timer_ext_clk));
      chk("soc", 32'(ext[12]), 32'(per_o.converter_start_trigger));
    end
    chk("conv1", 32'h0000_0003, 32'(per_o.first_conv_en));
    chk("conv2", 32'h0000_0003, 32'(per_o.second_conv_en));
    chk("in_oe_n", 32'h0000_007f,
        32'({pad_o.oe_n[12:10], pad_o.oe_n[3:0]}));
    rst <= 1'b1;
    wt(4);
    rst <= 1'b0;
    wt(1);
    chk("oe_n_rst2", 32'h0000_1fff, 32'(pad_o.oe_n));
    bus(1'b0, SPM_OFF_FUNC, 32'h0000_0000, "func_rst2");
    wt(2);
    give_verdict();
  end
endmodule
`default_nettype wire
